// ===== logic/mrd_defines.vh
// field positions, widths and reset values of the receive descriptor engine
`ifndef MRD_DEFINES_VH
`define MRD_DEFINES_VH
`define MRD_ST_OWN 31
`define MRD_ST_DAF 30
`define MRD_ST_LEN_HI 29
`define MRD_ST_LEN_LO 16
`define MRD_ST_ES 15
`define MRD_ST_TRUNC 14
`define MRD_ST_SAF 13
`define MRD_ST_LENERR 12
`define MRD_ST_OVF 11
`define MRD_ST_VLAN 10
`define MRD_ST_FIRST 9
`define MRD_ST_LAST 8
`define MRD_ST_IPC 7
`define MRD_ST_LCOL 6
`define MRD_ST_ETYPE 5
`define MRD_ST_WDT 4
`define MRD_ST_RXERR 3
`define MRD_ST_DRIB 2
`define MRD_ST_CRC 1
`define MRD_ST_ADDR 0
`define MRD_CT_NOINT 31
`define MRD_CT_EOR 25
`define MRD_CT_CHAIN 24
`define MRD_CT_SZ2_HI 21
`define MRD_CT_SZ2_LO 11
`define MRD_CT_SZ1_HI 10
`define MRD_CT_SZ1_LO 0
`define MRD_DESC_BYTES 32'h00000010
`define MRD_WORD_BYTES 12'h004
`define MRD_APPEND_BYTES 14'h0002
`define MRD_ADDR_RESET 32'h00000000
`endif

// ===== logic/mrd_next_addr.v
// next descriptor address: end of ring, chained pointer or consecutive entry
`timescale 1ns/1ns
`include "mrd_defines.vh"
module mrd_next_addr #(
  parameter ALIGN_BITS = 3
) (
  input wire [31:0] cur_addr,
  input wire [31:0] ctl,
  input wire [31:0] buf2_addr,
  input wire [31:0] list_base,
  output reg [31:0] next_addr
);
  // end of ring wins over chaining, chained pointer ignores its low bits
  always @* begin
    if (ctl[`MRD_CT_EOR]) begin
      next_addr = list_base; // [RULE_22] [RULE_23]
    end else if (ctl[`MRD_CT_CHAIN]) begin
      next_addr = {buf2_addr[31:ALIGN_BITS], {ALIGN_BITS{1'b0}}}; // [RULE_02]
    end else begin
      next_addr = cur_addr + `MRD_DESC_BYTES; // [RULE_02]
    end
  end
endmodule // mrd_next_addr

// ===== logic/mrd_rx_dma.v
// receive descriptor walker: fetch, fill buffers, write back status
//
// How it works
// [RULE_01] separate receive and transmit list bases, each loaded from its own register
// [RULE_02] walk forward: consecutive entries or chained pointer; two buffers at most
// [RULE_03] one buffer never holds two frames; frame end moves to a new descriptor
// [RULE_04] software aligns each descriptor to the bus width
// [RULE_05] always fetch the next descriptor before closing the current one
// [RULE_06] frame overflowing buffers with next not owned: truncate, set truncation flag
// [RULE_07] ownership bit 31 cleared on write-back when frame done or buffers full
// [RULE_08] bit 30 destination filter fail, bit 13 source filter fail
// [RULE_09] bits 29:16 byte count with CRC, plus two appended bytes if enabled
// [RULE_10] bit 15 error summary OR of listed error bits, last descriptor only
// [RULE_11] bit 12 length mismatch, only for 802.3 frames without CRC error
// [RULE_12] bit 11 overflow corrupted the frame
// [RULE_13] bit 10 VLAN tagged frame
// [RULE_14] bit 9 first descriptor, zero-size buffers skipped; bit 8 last descriptor
// [RULE_15] bit 7 IPv4 header checksum mismatch, kept out of summary in engine mode
// [RULE_16] bit 6 late collision in half duplex
// [RULE_17] bit 5 length/type field at least 0x0600
// [RULE_18] bit 4 receive watchdog expired, frame truncated
// [RULE_19] bit 3 receive error, bit 2 dribble in MII mode, bit 1 CRC error
// [RULE_20] bit 0 upper address match, or payload checksum error with full offload
// [RULE_21] control bit 31 suppresses the completion indication for that frame
// [RULE_22] control bit 25 returns to the list base, forming a ring
// [RULE_23] end of ring wins over chaining
// [RULE_24] control bits 10:0 and 21:11 give buffer sizes; zero first size skipped
// [RULE_25] all status goes out in the single write that clears ownership
`timescale 1ns/1ns
`include "mrd_defines.vh"
module mrd_rx_dma #(
  parameter ALIGN_BITS = 3
) (
  input wire clk,
  input wire rst,
  input wire list_load,
  input wire [31:0] rx_list_base,
  input wire [31:0] tx_list_base,
  input wire rx_poll,
  input wire full_offload,
  input wire ipc_engine_on,
  input wire mii_mode,
  input wire type1_on,
  input wire ctrl_frame,
  input wire rx_valid,
  input wire [31:0] rx_data,
  input wire [2:0] rx_bytes,
  input wire rx_last,
  input wire dest_filter_fail,
  input wire src_filter_fail,
  input wire length_mismatch_flag,
  input wire overflow_err,
  input wire vlan_tag,
  input wire ipc_chk_err,
  input wire late_collision_flag,
  input wire ethertype_frame_flag,
  input wire rx_watchdog_expired,
  input wire rx_line_error_flag,
  input wire dribble_err,
  input wire crc_err,
  input wire addr_hi_or_pce,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  output reg rx_ready_q,
  output reg mem_req_q,
  output reg mem_we_q,
  output reg [31:0] mem_addr_q,
  output reg [31:0] mem_wdata_q,
  output reg rx_complete_status_q,
  output reg suspended_q,
  output reg [31:0] rx_list_base_reg_q,
  output reg [31:0] tx_list_base_reg_q,
  output reg [31:0] cur_desc_addr_q
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_RD = 7'h02;
  localparam [6:0] S_DATA = 7'h04;
  localparam [6:0] S_WR = 7'h08;
  localparam [6:0] S_CLOSE = 7'h10;
  localparam [6:0] S_DROP = 7'h20;
  localparam [6:0] S_SUSP = 7'h40;

  reg [6:0] state_q;
  reg [1:0] wi_q;
  reg [31:0] nxt_addr_q;
  reg n_own_q;
  reg [31:0] n_ctl_q;
  reg [31:0] n_b1_q;
  reg [31:0] n_b2_q;
  reg [31:0] cur_ctl_q;
  reg [31:0] cur_b2_q;
  reg open_q;
  reg eof_q;
  reg trunc_q;
  reg in_frame_q;
  reg first_q;
  reg buf_sel_q;
  reg [11:0] buf_left_q;
  reg [31:0] ptr_q;
  reg [13:0] cnt_q;
  reg [2:0] bytes_q;
  reg last_q;
  reg [12:0] flg_q;
  wire [31:0] after_next;
  wire [31:0] status_word;
  wire [12:0] live_flags;
  wire take;

  // second buffer usable only when not used as the chain pointer
  function buf2_ok;
    input [31:0] ctl;
    begin
      buf2_ok = ~ctl[`MRD_CT_CHAIN] & (ctl[`MRD_CT_SZ2_HI:`MRD_CT_SZ2_LO] != 11'h000);
    end
  endfunction

  // first buffer size widened to the byte counter
  function [11:0] size1;
    input [31:0] ctl;
    begin
      size1 = {1'b0, ctl[`MRD_CT_SZ1_HI:`MRD_CT_SZ1_LO]};
    end
  endfunction

  // second buffer size widened to the byte counter
  function [11:0] size2;
    input [31:0] ctl;
    begin
      size2 = {1'b0, ctl[`MRD_CT_SZ2_HI:`MRD_CT_SZ2_LO]};
    end
  endfunction

  assign take = rx_valid & rx_ready_q;
  assign live_flags = {addr_hi_or_pce, crc_err, dribble_err, rx_line_error_flag,
    rx_watchdog_expired, ethertype_frame_flag, late_collision_flag, ipc_chk_err,
    vlan_tag, overflow_err, length_mismatch_flag, src_filter_fail, dest_filter_fail};

  // address of the descriptor after the one just fetched
  mrd_next_addr #(
    .ALIGN_BITS(ALIGN_BITS)
  ) u_next (
    .cur_addr(nxt_addr_q),
    .ctl(n_ctl_q),
    .buf2_addr(n_b2_q),
    .list_base(rx_list_base_reg_q),
    .next_addr(after_next)
  );

  // status word of the descriptor being closed
  mrd_status_pack u_pack (
    .flags(flg_q),
    .full_offload(full_offload),
    .ipc_engine_on(ipc_engine_on),
    .mii_mode(mii_mode),
    .type1_append(type1_on & ~ctrl_frame),
    .first(first_q),
    .last(eof_q | trunc_q),
    .trunc(trunc_q),
    .count(cnt_q),
    .status(status_word)
  );

  // walker state machine and memory master
  always @(posedge clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      wi_q <= 2'd0;
      nxt_addr_q <= `MRD_ADDR_RESET;
      n_own_q <= 1'b0;
      n_ctl_q <= 32'h00000000;
      n_b1_q <= 32'h00000000;
      n_b2_q <= 32'h00000000;
      cur_ctl_q <= 32'h00000000;
      cur_b2_q <= 32'h00000000;
      open_q <= 1'b0;
      eof_q <= 1'b0;
      trunc_q <= 1'b0;
      in_frame_q <= 1'b0;
      first_q <= 1'b0;
      buf_sel_q <= 1'b0;
      buf_left_q <= 12'h000;
      ptr_q <= 32'h00000000;
      cnt_q <= 14'h0000;
      bytes_q <= 3'h0;
      last_q <= 1'b0;
      flg_q <= 13'h0000;
      rx_ready_q <= 1'b0;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= `MRD_ADDR_RESET;
      mem_wdata_q <= 32'h00000000;
      rx_complete_status_q <= 1'b0;
      suspended_q <= 1'b0;
      rx_list_base_reg_q <= `MRD_ADDR_RESET;
      tx_list_base_reg_q <= `MRD_ADDR_RESET;
      cur_desc_addr_q <= `MRD_ADDR_RESET;
    end else begin
      rx_complete_status_q <= 1'b0;
      // list bases load together; only in idle do they also start the receive walk
      if (list_load) begin
        rx_list_base_reg_q <= rx_list_base; // [RULE_01]
        tx_list_base_reg_q <= tx_list_base; // [RULE_01]
      end
      case (state_q)
        S_IDLE: begin
          if (list_load) begin
            nxt_addr_q <= rx_list_base; // [RULE_01]
            state_q <= S_RD;
            wi_q <= 2'd0;
            mem_req_q <= 1'b1;
            mem_we_q <= 1'b0;
            mem_addr_q <= rx_list_base;
          end
        end
        S_RD: begin
          // four-word descriptor read, back to back
          if (mem_ack) begin
            case (wi_q)
              2'd0: n_own_q <= mem_rdata[`MRD_ST_OWN];
              2'd1: n_ctl_q <= mem_rdata;
              2'd2: n_b1_q <= mem_rdata;
              default: n_b2_q <= mem_rdata;
            endcase
            wi_q <= wi_q + 2'd1;
            mem_addr_q <= mem_addr_q + {29'h00000000, 3'h4};
            if (wi_q == 2'd3) begin
              mem_req_q <= 1'b0;
              wi_q <= 2'd0;
              if (open_q) begin
                state_q <= S_CLOSE; // [RULE_05]
                if (!eof_q && !n_own_q) begin
                  trunc_q <= 1'b1; // [RULE_06]
                  flg_q <= live_flags;
                end
              end else if (n_own_q) begin
                state_q <= S_CLOSE;
                wi_q <= 2'd2;
              end else begin
                state_q <= S_SUSP;
                suspended_q <= 1'b1;
              end
            end
          end
        end
        S_DATA: begin
          // one data word taken, written at the buffer pointer
          if (take) begin
            rx_ready_q <= 1'b0;
            bytes_q <= rx_bytes;
            last_q <= rx_last;
            if (rx_last) begin
              flg_q <= live_flags;
            end
            if (!in_frame_q) begin
              first_q <= 1'b1; // [RULE_14]
              in_frame_q <= 1'b1;
            end
            state_q <= S_WR;
            mem_req_q <= 1'b1;
            mem_we_q <= 1'b1;
            mem_addr_q <= ptr_q;
            mem_wdata_q <= rx_data;
          end
        end
        S_WR: begin
          if (mem_ack) begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            ptr_q <= ptr_q + 32'h00000004;
            cnt_q <= cnt_q + {11'h000, bytes_q}; // [RULE_09]
            if (last_q) begin
              // frame ended: the rest of this buffer stays unused
              eof_q <= 1'b1; // [RULE_03]
              state_q <= S_RD;
              mem_req_q <= 1'b1;
              mem_addr_q <= nxt_addr_q;
            end else if (buf_left_q != `MRD_WORD_BYTES) begin
              buf_left_q <= buf_left_q - `MRD_WORD_BYTES;
              state_q <= S_DATA;
              rx_ready_q <= 1'b1;
            end else if (!buf_sel_q && buf2_ok(cur_ctl_q)) begin
              buf_sel_q <= 1'b1; // [RULE_02]
              buf_left_q <= size2(cur_ctl_q);
              ptr_q <= cur_b2_q;
              state_q <= S_DATA;
              rx_ready_q <= 1'b1;
            end else begin
              // buffers full mid-frame: look ahead before closing
              state_q <= S_RD; // [RULE_05]
              mem_req_q <= 1'b1;
              mem_addr_q <= nxt_addr_q;
            end
          end
        end
        S_CLOSE: begin
          // wi 0 issues status write, 1 waits, 2 adopts the fetched descriptor
          if (wi_q == 2'd0) begin
            wi_q <= 2'd1;
            mem_req_q <= 1'b1;
            mem_we_q <= 1'b1;
            mem_addr_q <= cur_desc_addr_q;
            mem_wdata_q <= status_word; // [RULE_07] [RULE_25]
          end else if (wi_q == 2'd1) begin
            if (mem_ack) begin
              mem_req_q <= 1'b0;
              mem_we_q <= 1'b0;
              open_q <= 1'b0;
              first_q <= 1'b0;
              if ((eof_q || trunc_q) && !cur_ctl_q[`MRD_CT_NOINT]) begin
                rx_complete_status_q <= 1'b1; // [RULE_21]
              end
              if (eof_q || trunc_q) begin
                cnt_q <= 14'h0000;
                flg_q <= 13'h0000;
              end
              if (eof_q) begin
                in_frame_q <= 1'b0;
              end
              eof_q <= 1'b0;
              if (trunc_q) begin
                // drop the remainder of the frame
                state_q <= S_DROP; // [RULE_06]
                rx_ready_q <= 1'b1;
                wi_q <= 2'd0;
              end else if (n_own_q) begin
                wi_q <= 2'd2;
              end else begin
                state_q <= S_SUSP;
                suspended_q <= 1'b1;
                wi_q <= 2'd0;
              end
            end
          end else begin
            // adopt the looked-ahead descriptor and point at the one after it
            open_q <= 1'b1;
            wi_q <= 2'd0;
            cur_desc_addr_q <= nxt_addr_q;
            nxt_addr_q <= after_next; // [RULE_02] [RULE_22]
            cur_ctl_q <= n_ctl_q;
            cur_b2_q <= n_b2_q;
            if (size1(n_ctl_q) != 12'h000) begin
              buf_sel_q <= 1'b0;
              buf_left_q <= size1(n_ctl_q); // [RULE_24]
              ptr_q <= n_b1_q;
              state_q <= S_DATA;
              rx_ready_q <= 1'b1;
            end else if (buf2_ok(n_ctl_q)) begin
              buf_sel_q <= 1'b1; // [RULE_24]
              buf_left_q <= size2(n_ctl_q);
              ptr_q <= n_b2_q;
              state_q <= S_DATA;
              rx_ready_q <= 1'b1;
            end else begin
              // no usable buffer: close it empty after looking ahead
              state_q <= S_RD; // [RULE_14]
              mem_req_q <= 1'b1;
              mem_we_q <= 1'b0;
              mem_addr_q <= after_next;
            end
          end
        end
        S_DROP: begin
          if (take && rx_last) begin
            rx_ready_q <= 1'b0;
            trunc_q <= 1'b0;
            in_frame_q <= 1'b0;
            state_q <= S_SUSP;
            suspended_q <= 1'b1;
          end
        end
        S_SUSP: begin
          // wait for software to hand over the next descriptor
          if (rx_poll) begin
            suspended_q <= 1'b0;
            state_q <= S_RD;
            wi_q <= 2'd0;
            mem_req_q <= 1'b1;
            mem_we_q <= 1'b0;
            mem_addr_q <= nxt_addr_q;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // mrd_rx_dma

// ===== logic/mrd_status_pack.v
// packs the receive status word written back when a descriptor closes
`timescale 1ns/1ns
`include "mrd_defines.vh"
module mrd_status_pack (
  input wire [12:0] flags,
  input wire full_offload,
  input wire ipc_engine_on,
  input wire mii_mode,
  input wire type1_append,
  input wire first,
  input wire last,
  input wire trunc,
  input wire [13:0] count,
  output reg [31:0] status
);
  // flags: 0 daf,1 saf,2 lenerr,3 ovf,4 vlan,5 ipc,6 lcol,7 etype,8 wdt,9 rxerr,
  // 10 dribble,11 crc,12 addr-hi or payload checksum
  reg es;
  reg crc;
  reg ipc_es;
  reg pce;
  always @* begin
    crc = flags[11] & last; // [RULE_19]
    pce = flags[12] & full_offload;
    ipc_es = flags[5] & ~ipc_engine_on; // [RULE_15]
    es = last & (pce | crc | flags[9] | flags[8] | flags[6] | ipc_es | flags[3]
      | trunc); // [RULE_10]
    status = 32'h00000000;
    status[`MRD_ST_OWN] = 1'b0; // [RULE_07]
    status[`MRD_ST_DAF] = flags[0]; // [RULE_08]
    status[`MRD_ST_LEN_HI:`MRD_ST_LEN_LO] = count
      + ((last & type1_append) ? `MRD_APPEND_BYTES : 14'h0000); // [RULE_09]
    status[`MRD_ST_ES] = es; // [RULE_10]
    status[`MRD_ST_TRUNC] = trunc & last; // [RULE_06]
    status[`MRD_ST_SAF] = flags[1]; // [RULE_08]
    status[`MRD_ST_LENERR] = flags[2] & ~flags[7] & ~flags[11]; // [RULE_11]
    status[`MRD_ST_OVF] = flags[3]; // [RULE_12]
    status[`MRD_ST_VLAN] = flags[4]; // [RULE_13]
    status[`MRD_ST_FIRST] = first; // [RULE_14]
    status[`MRD_ST_LAST] = last; // [RULE_14]
    status[`MRD_ST_IPC] = flags[5]; // [RULE_15]
    status[`MRD_ST_LCOL] = flags[6]; // [RULE_16]
    status[`MRD_ST_ETYPE] = flags[7]; // [RULE_17]
    status[`MRD_ST_WDT] = flags[8]; // [RULE_18]
    status[`MRD_ST_RXERR] = flags[9]; // [RULE_19]
    status[`MRD_ST_DRIB] = flags[10] & mii_mode; // [RULE_19]
    status[`MRD_ST_CRC] = crc; // [RULE_19]
    status[`MRD_ST_ADDR] = flags[12]; // [RULE_20]
  end
endmodule // mrd_status_pack

// ===== test/mrd_host_mem.sv
// host memory with descriptors and buffers, answering after a random wait when slow
`timescale 1ns/1ns
module mrd_host_mem (
  input wire clk,
  input wire rst,
  input wire slow,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  output reg mem_ack,
  output wire [31:0] mem_rdata
);
  reg [31:0] m [0:1023];
  reg [31:0] rd_q = 32'h0;
  reg [2:0] wait_q = 3'h0;
  // one access at a time, stalled by a random wait when slow
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    if (rst) begin
      wait_q <= 3'h0;
    end else if (mem_req && !mem_ack) begin
      if (wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
      end else begin
        mem_ack <= 1'b1;
        wait_q <= slow ? 3'($urandom_range(5)) : 3'h0;
        if (mem_we) begin
          m[mem_addr[11:2]] <= mem_wdata;
        end else begin
          rd_q <= m[mem_addr[11:2]];
        end
      end
    end
  end
  // read data only meaningful with ack, inverted junk otherwise
  assign mem_rdata = mem_ack ? rd_q : ~rd_q;
endmodule // mrd_host_mem

// ===== test/mrd_rx_dma_assertions.sv
// assertions on the receive descriptor walker ports
`timescale 1ns/1ns
module mrd_rx_dma_chk (
  input wire clk,
  input wire rst,
  input wire list_load,
  input wire [31:0] rx_list_base,
  input wire rx_valid,
  input wire [31:0] rx_data,
  input wire rx_last,
  input wire mem_ack,
  input wire rx_ready_q,
  input wire mem_req_q,
  input wire mem_we_q,
  input wire [31:0] mem_addr_q,
  input wire [31:0] mem_wdata_q,
  input wire rx_complete_status_q,
  input wire suspended_q,
  input wire [31:0] rx_list_base_reg_q,
  input wire [31:0] cur_desc_addr_q
);
  wire take = rx_valid && rx_ready_q;
  wire st_wr = mem_req_q && mem_we_q && mem_addr_q == cur_desc_addr_q;
  wire [31:0] w = mem_wdata_q;
  reg go_q;
  reg drain_q;
  reg cl_q;
  // walk started, truncation drain running, last status write acked
  always @(posedge clk) begin
    if (rst) begin
      go_q <= 1'b0;
      drain_q <= 1'b0;
      cl_q <= 1'b0;
    end else begin
      go_q <= go_q | list_load;
      drain_q <= (st_wr && mem_ack && w[14]) | (drain_q & ~(take & rx_last));
      cl_q <= st_wr && mem_ack && w[8];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_list_base: assert property (list_load |=>
    rx_list_base_reg_q == $past(rx_list_base)) else $error("list base not loaded");
  chk_first_fetch: assert property (list_load && !go_q |=> mem_req_q && !mem_we_q
    && mem_addr_q == $past(rx_list_base)) else $error("walk not started at base");
  chk_req_hold: assert property (mem_req_q && !mem_ack |=> mem_req_q && $stable(mem_we_q)
    && $stable(mem_addr_q) && $stable(mem_wdata_q)) else $error("request changed before ack");
  chk_desc_stride: assert property (mem_req_q && mem_ack && !mem_we_q
    && mem_addr_q[3:2] != 2'h3 |=> mem_req_q && !mem_we_q
    && mem_addr_q == $past(mem_addr_q) + 32'h4) else $error("descriptor words not consecutive");
  chk_take_write: assert property (take && !drain_q |=> !rx_ready_q && mem_req_q
    && mem_we_q && mem_wdata_q == $past(rx_data)) else $error("taken word not written");
  chk_busy_ready: assert property (mem_req_q && mem_we_q |-> !rx_ready_q)
    else $error("ready while write pending");
  chk_own_cleared: assert property (st_wr |-> !w[31])
    else $error("status write keeps ownership");
  chk_trunc_last: assert property (st_wr && w[14] |-> w[8] && w[15])
    else $error("truncation without last or summary");
  chk_err_summary: assert property (st_wr && w[8]
    && |{w[1], w[3], w[4], w[6], w[11], w[14]} |-> w[15]) else $error("error summary missing");
  chk_cmpl_cause: assert property (rx_complete_status_q |-> cl_q)
    else $error("completion without closed last descriptor");
  chk_cmpl_pulse: assert property (rx_complete_status_q |=> !rx_complete_status_q)
    else $error("completion longer than one cycle");
  cover property ($rose(rx_complete_status_q));
  cover property (st_wr && mem_ack && w[14]);
  cover property ($rose(suspended_q));
endmodule // mrd_rx_dma_chk
bind mrd_rx_dma mrd_rx_dma_chk chk (.clk, .rst, .list_load, .rx_list_base, .rx_valid, .rx_data,
  .rx_last, .mem_ack, .rx_ready_q, .mem_req_q, .mem_we_q, .mem_addr_q, .mem_wdata_q,
  .rx_complete_status_q, .suspended_q, .rx_list_base_reg_q, .cur_desc_addr_q);

// ===== test/tb_top.sv
// self-checking bench for the receive descriptor walker
`timescale 1ns/1ns
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg list_load = 1'b0;
  reg rx_poll = 1'b0;
  reg [31:0] base_a = 32'h00000100;
  reg [31:0] txb_a = 32'h00000800;
  reg [4:0] md = 5'h00;
  reg rx_valid = 1'b0;
  reg [31:0] rx_data = 32'h0;
  reg [2:0] rx_bytes = 3'h4;
  reg rx_last = 1'b0;
  reg [12:0] fl = 13'h0;
  reg slow = 1'b0;
  reg z_a [0:3];
  reg ni_a [0:3];
  reg [31:0] dat [0:19];
  integer cap_a [0:3];
  integer n_errors = 0;
  integer checks_done = 0;
  integer n_cmpl = 0;
  integer j, w, sd;
  wire mem_ack, rx_ready_q, mem_req_q, mem_we_q, rx_complete_status_q, suspended_q;
  wire [31:0] mem_rdata, mem_addr_q, mem_wdata_q, rxb, txb, cda;
  mrd_rx_dma #(.ALIGN_BITS(3)) uut (.clk(clk), .rst(rst), .list_load(list_load),
    .rx_list_base(base_a), .tx_list_base(txb_a), .rx_poll(rx_poll), .full_offload(md[4]),
    .ipc_engine_on(md[3]), .mii_mode(md[2]), .type1_on(md[1]), .ctrl_frame(md[0]),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_bytes(rx_bytes), .rx_last(rx_last),
    .dest_filter_fail(fl[0]), .src_filter_fail(fl[1]), .length_mismatch_flag(fl[2]),
    .overflow_err(fl[3]), .vlan_tag(fl[4]), .ipc_chk_err(fl[5]), .late_collision_flag(fl[6]),
    .ethertype_frame_flag(fl[7]), .rx_watchdog_expired(fl[8]), .rx_line_error_flag(fl[9]),
    .dribble_err(fl[10]), .crc_err(fl[11]), .addr_hi_or_pce(fl[12]), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .rx_ready_q(rx_ready_q), .mem_req_q(mem_req_q), .mem_we_q(mem_we_q),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
    .rx_complete_status_q(rx_complete_status_q), .suspended_q(suspended_q),
    .rx_list_base_reg_q(rxb), .tx_list_base_reg_q(txb), .cur_desc_addr_q(cda));
  mrd_host_mem mem (.clk(clk), .rst(rst), .slow(slow), .mem_req(mem_req_q), .mem_we(mem_we_q),
    .mem_addr(mem_addr_q), .mem_wdata(mem_wdata_q), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // clock and completion pulse counter
  always #5 clk = ~clk;
  always @(posedge clk) if (rx_complete_status_q === 1'b1) n_cmpl = n_cmpl + 1;
  // compare and count
  task check(input [31:0] seen, input [31:0] exp, input [8*10:1] what);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: %0s got %h want %h", $time, what, seen, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // status word expected for a single-descriptor frame
  function [31:0] exp_st(input [13:0] cnt);
    reg [31:0] s;
    begin
      s = {1'b0, fl[0], cnt, 2'h0, fl[1], fl[2] & ~fl[7] & ~fl[11], fl[3], fl[4], 2'h3,
        fl[5], fl[6], fl[7], fl[8], fl[9], fl[10] & md[2], fl[11], fl[12]};
      s[15] = |{s[1], s[3], s[4], s[6], s[11], s[7] & ~md[3], s[0] & md[4]};
      exp_st = s;
    end
  endfunction
  // host builds descriptor k owned; 1 chained, 3 end of ring plus chained
  task arm(input integer k, input zok);
    integer d;
    reg ch;
    begin
      d = (base_a >> 2) + 4 * k;
      ch = (k == 1) || (k == 3);
      z_a[k] = zok && !ch && ($urandom % 2);
      ni_a[k] = $urandom % 2;
      cap_a[k] = ch ? 4 : (z_a[k] ? 12 : 16);
      mem.m[d] = 32'h80000000;
      mem.m[d + 1] = {ni_a[k], 5'h00, k == 3, ch, 2'h0, 11'h030,
        z_a[k] ? 11'h000 : 11'h010};
      mem.m[d + 2] = 32'h400 + 32'h80 * k;
      mem.m[d + 3] = ch ? (k == 1 ? base_a + 32'h20 : 32'h300) : 32'h440 + 32'h80 * k;
    end
  endtask
  // send one frame into descriptor k, wait for its close and check it
  task run(input integer k, input integer n, input tr);
    integer i, c0, d, a;
    reg [2:0] lb;
    reg [31:0] ex;
    begin
      d = (base_a >> 2) + 4 * k;
      lb = 3'($urandom_range(4, 1));
      fl = 13'($urandom);
      md = 5'($urandom);
      slow = $urandom % 2;
      c0 = n_cmpl;
      for (i = 0; i < n; i = i + 1) begin
        dat[i] = $urandom;
        rx_valid = 1'b1;
        rx_data = dat[i];
        rx_last = i == n - 1;
        rx_bytes = rx_last ? lb : 3'h4;
        w = 0;
        // ready looked at while settled; the word goes at the following edge
        while (rx_ready_q !== 1'b1 && w < 300) begin
          w = w + 1;
          @(posedge clk);
          #1;
        end
        check(w < 300, 1, "ready");
        @(posedge clk);
        #1;
      end
      rx_valid = 1'b0;
      rx_last = 1'b0;
      w = 0;
      while (mem.m[d][31] !== 1'b0 && w < 500) begin
        w = w + 1;
        @(posedge clk);
      end
      repeat (3) @(posedge clk);
      #1;
      check(w < 500, 1, "close");
      if (tr) begin
        check(mem.m[d] & 32'h8000C100, 32'h0000C100, "truncated");
      end else begin
        ex = exp_st(14'(4 * n - 4 + lb + ((md[1] && !md[0]) ? 2 : 0)));
        check(mem.m[d], ex, "status");
        for (i = 0; i < n; i = i + 1) begin
          a = 256 + 32 * k + (z_a[k] ? 16 + i : (i < 4 ? i : 12 + i));
          check(mem.m[a], dat[i], "data");
        end
        check(n_cmpl - c0, !ni_a[k], "complete");
        // next descriptor adopted: consecutive entry, or the list base after the last
        check(cda, base_a + 32'h10 * ((k + 1) % 4), "cur desc");
      end
    end
  endtask
  initial begin
    #500000;
    n_errors = n_errors + 1;
    print_verdict;
  end
  // reset, start the walk, ring traffic, truncation and resume
  initial begin
    sd = $urandom(36);
    for (j = 0; j < 4; j = j + 1) arm(j, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    list_load = 1'b1;
    @(posedge clk);
    #1;
    list_load = 1'b0;
    check(rxb, base_a, "rx base");
    check(txb, txb_a, "tx base");
    for (j = 0; j < 24; j = j + 1) begin
      run(j % 4, j % 6 == 0 ? cap_a[j % 4] : $urandom_range(cap_a[j % 4], 1), 1'b0);
      arm(j % 4, 1'b1);
    end
    mem.m[(base_a >> 2) + 4] = 32'h0;
    run(0, cap_a[0] + 4, 1'b1);
    w = 0;
    while (suspended_q !== 1'b1 && w < 100) begin
      w = w + 1;
      @(posedge clk);
    end
    #1;
    check(suspended_q, 1, "suspend");
    arm(1, 1'b1);
    rx_poll = 1'b1;
    @(posedge clk);
    #1;
    rx_poll = 1'b0;
    run(1, $urandom_range(cap_a[1], 1), 1'b0);
    print_verdict;
  end
endmodule // tb_top
